// [tb/lcd_keyscan_control_decode_asserts.sv]
// Port checks for the control decoder
module lcd_keyscan_control_decode_asserts
    import lcd_keyscan_pkg::*;
(
    input wire logic                    clk_in,
    input wire logic                    rst_in,
    input wire logic                    chip_enable_in,
    input wire logic [SENSE_INPUTS-1:0] scan_sense_inputs_in,
    input wire logic                    scan_busy_in,
    input wire control_type             control_out,
    input wire logic                    lcd_drive_enable_out,
    input wire logic                    segment_off_wave_out,
    input wire logic                    shared_common_segment_out,
    input wire logic                    osc_source_external_out,
    input wire logic                    osc_run_out,
    input wire scan_lines_type          scan_drive_lines_out,
    input wire ports_type               shared_segment_port_pins_out,
    input wire logic                    scan_start_out,
    input wire logic                    key_data_clear_out,
    input wire logic                    data_out_release_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_sleep_drive: assert property (
        1'b1 |=> lcd_drive_enable_out == !$past(control_out.sleep_select))
        else $error("lcd drive wrong");
    a_osc_stop: assert property (
        (control_out.sleep_select && !scan_busy_in) [*3] |-> !osc_run_out)
        else $error("osc runs in sleep");
    a_osc_keep: assert property (
        (!control_out.sleep_select || scan_busy_in) [*3] |-> osc_run_out)
        else $error("osc stopped");
    a_blank_wave: assert property (
        1'b1 |=> segment_off_wave_out == $past(control_out.segment_blank_bit))
        else $error("blank wrong");
    a_duty_share: assert property (
        1'b1 |=> shared_common_segment_out == $past(control_out.duty_select_bit))
        else $error("shared pin wrong");
    a_osc_mode: assert property (
        1'b1 |=> osc_source_external_out == $past(control_out.osc_source_bit))
        else $error("osc mode wrong");
    a_scan_off: assert property (
        control_out.scan_disable_bit [*3] |->
            !scan_start_out && key_data_clear_out && data_out_release_out)
        else $error("scan not off");
    a_busy_block: assert property (
        scan_busy_in [*2] |-> !scan_start_out)
        else $error("start while busy");
    a_start_pulse: assert property (
        scan_start_out |=> !scan_start_out)
        else $error("start too long");
    a_key_start: assert property (
        (!control_out.scan_disable_bit && !scan_busy_in && |scan_sense_inputs_in) [*4] |->
            scan_start_out || $past(scan_start_out))
        else $error("no scan start");
    a_quiet_lines: assert property (
        ((scan_drive_lines_out.drive_enable & ~scan_drive_lines_out.level) == 6'h00) &&
        ((shared_segment_port_pins_out.port_level &
          ~shared_segment_port_pins_out.port_mode) == 4'h0))
        else $error("quiet line driven");
    a_ctrl_hold: assert property (
        chip_enable_in |=> $stable(control_out))
        else $error("control moved mid frame");
    c_start: cover property (scan_start_out);
    c_load: cover property ($changed(control_out));
    c_sleep_scan: cover property (osc_run_out && control_out.sleep_select);
endmodule
bind lcd_keyscan_control_decode lcd_keyscan_control_decode_asserts
    lcd_keyscan_control_decode_asserts_i (
    .clk_in,
    .rst_in,
    .chip_enable_in,
    .scan_sense_inputs_in,
    .scan_busy_in,
    .control_out,
    .lcd_drive_enable_out,
    .segment_off_wave_out,
    .shared_common_segment_out,
    .osc_source_external_out,
    .osc_run_out,
    .scan_drive_lines_out,
    .shared_segment_port_pins_out,
    .scan_start_out,
    .key_data_clear_out,
    .data_out_release_out);

// [tb/serial_ctrl_model.sv]
// Controller model driving the three-wire link
module serial_ctrl_model
    import lcd_keyscan_pkg::*;
(
    output logic serial_clock_out,
    output logic chip_enable_out,
    output logic serial_data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        serial_clock_out = 1'b0;
        chip_enable_out  = 1'b0;
        serial_data_out  = 1'b0;
    end
    // Clock runs only inside frames, data moves after the falling edge
    task automatic send(input logic [7:0] a, input logic [FRAME_BITS-1:0] d, input int n);
        for (int i = 0; i < ADDR_BITS + n; i++) begin
            if (i == ADDR_BITS) chip_enable_out = 1'b1;
            serial_data_out = (i < ADDR_BITS) ? a[ADDR_BITS-1-i] : d[n-1-(i-ADDR_BITS)];
            #7.5 serial_clock_out = 1'b1;
            #7.5 serial_clock_out = 1'b0;
        end
        // Released line must not keep showing the last bit
        serial_data_out = ~serial_data_out;
        #7.5 chip_enable_out = 1'b0;
    endtask
endmodule

// [tb/tb_lcd_keyscan_control_decode.sv]
// Self-checking bench for the control decoder
module tb_lcd_keyscan_control_decode
    import lcd_keyscan_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic                    clk_in, rst_in, sclk, ce, sdi, busy, lcd, seg_off, shcom;
    logic                    osc_ext, osc_run, start, key_clr, do_rel;
    logic [SENSE_INPUTS-1:0] sense;
    control_type             control_out, c;
    scan_lines_type          lines;
    ports_type               ports;
    int                      miscompares = 0, checked = 0, pulses;
    serial_ctrl_model serial_ctrl_model_i (.serial_clock_out(sclk), .chip_enable_out(ce),
        .serial_data_out(sdi));
    lcd_keyscan_control_decode lcd_keyscan_control_decode_i (.clk_in(clk_in), .rst_in(rst_in),
        .serial_clock_in(sclk), .chip_enable_in(ce), .serial_data_in(sdi),
        .scan_sense_inputs_in(sense),
        .scan_busy_in(busy), .control_out(control_out), .lcd_drive_enable_out(lcd),
        .segment_off_wave_out(seg_off), .shared_common_segment_out(shcom),
        .osc_source_external_out(osc_ext), .osc_run_out(osc_run), .scan_drive_lines_out(lines),
        .shared_segment_port_pins_out(ports), .scan_start_out(start),
        .key_data_clear_out(key_clr), .data_out_release_out(do_rel));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic complete_run();
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Long CE-low gap keeps frames apart and lets the load land
    task automatic load(input logic [7:0] a, input logic [FRAME_BITS-1:0] d, input int n);
        serial_ctrl_model_i.send(a, d, n);
        repeat (12) @(negedge clk_in);
    endtask
    task automatic count_starts();
        pulses = 0;
        repeat (12) begin
            @(negedge clk_in);
            pulses += int'(start === 1'b1);
        end
    endtask
    // Display word 0x1109 sets D1, D4, D9, D13 so both duty maps differ
    task automatic verify(input control_type c);
        int n;
        logic [5:0] lvl, sel;
        logic [3:0] mode, lev;
        n = (c.scan_standby_level_field > 3'h6) ? 6 : int'(c.scan_standby_level_field);
        sel = (6'h01 << c.scan_pin_share_field) - 6'h01;
        mode = (5'h01 << ((c.port_select_field > 3'h4) ? 3'h4 : c.port_select_field)) - 5'h01;
        for (int i = 0; i < SCAN_LINES; i++) lvl[i] = (i >= n);
        for (int i = 0; i < SHARED_PORTS; i++) begin
            lev[i] = mode[i] & 1'(16'h1109 >> (c.duty_select_bit ? 3*i : 4*i));
        end
        check("control", control_out, c);
        check("lcd_drive", lcd, !c.sleep_select);
        check("osc_run", osc_run, !c.sleep_select);
        check("seg_off", seg_off, c.segment_blank_bit);
        check("shared_com", shcom, c.duty_select_bit);
        check("osc_ext", osc_ext, c.osc_source_bit);
        check("key_clear", key_clr, c.scan_disable_bit);
        check("level", lines.level, lvl);
        check("drive", lines.drive_enable, lvl & ~sel & {6{!c.scan_disable_bit}});
        check("segment", lines.segment_select, sel[2:0]);
        check("mode", ports.port_mode, mode);
        check("port_level", ports.port_level, lev);
    endtask
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    initial begin
        #100us;
        miscompares++;
        complete_run();
    end
    initial begin
        rst_in = 1'b1;
        busy = 1'b0;
        sense = 5'h00;
        repeat (3) @(negedge clk_in);
        rst_in = 1'b0;
        @(negedge clk_in);
        check("reset", control_out, CTRL_RESET);
        load(DISP_ADDR, 18'h01109, DISP_COUNT);
        for (int k = 0; k < 8; k++) begin
            c = {k[0], 3'(k), k[1], 2'(k), 3'(k), k[1], k[0], k[2], 3'(k), k[0] ^ k[1]};
            load(CTRL_ADDR, 18'(c), CTRL_BITS);
            verify(c);
        end
        // Wrong address or bit count must leave control alone
        load(CTRL_ADDR, 18'h3ffff, CTRL_BITS - 1);
        load(8'h80, 18'h3ffff, CTRL_BITS);
        check("refused", control_out, c);
        c = '0;
        c.sleep_select = 1'b1;
        load(CTRL_ADDR, 18'(c), CTRL_BITS);
        sense = 5'h01;
        count_starts();
        // Start shows 3 cycles after the pin, then every other cycle
        check("scan_in_sleep", pulses, 5);
        busy = 1'b1;
        repeat (3) @(negedge clk_in);
        check("osc_busy", osc_run, 1);
        busy = 1'b0;
        c.scan_disable_bit = 1'b1;
        load(CTRL_ADDR, 18'(c), CTRL_BITS);
        count_starts();
        check("scan_disabled", pulses, 0);
        check("do_release", do_rel, 1);
        // Mid-run reset must bring back the blanked, scan-off state
        rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        check("rst_ctrl", control_out, CTRL_RESET);
        check("rst_blank", seg_off, 1);
        check("rst_drive", lcd, 0);
        check("rst_release", do_rel, 1);
        rst_in = 1'b0;
        repeat (2) @(negedge clk_in);
        check("rst_lcd", lcd, 1);
        check("rst_osc", osc_run, 1);
        check("rst_start", start, 0);
        complete_run();
    end
endmodule

// [verilog/lcd_keyscan_control_decode.sv]
// Control decode for a segment LCD driver with key matrix scanning
module lcd_keyscan_control_decode
    import lcd_keyscan_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    serial_clock_in,
    input  wire logic                    chip_enable_in,
    input  wire logic                    serial_data_in,
    input  wire logic [SENSE_INPUTS-1:0] scan_sense_inputs_in,
    input  wire logic                    scan_busy_in,
    output control_type                  control_out,
    output logic                         lcd_drive_enable_out,
    output logic                         segment_off_wave_out,
    output logic                         shared_common_segment_out,
    output logic                         osc_source_external_out,
    output logic                         osc_run_out,
    output scan_lines_type               scan_drive_lines_out,
    output ports_type                    shared_segment_port_pins_out,
    output logic                         scan_start_out,
    output logic                         key_data_clear_out,
    output logic                         data_out_release_out
);

    typedef struct packed {
        logic                    ce_s1;
        logic                    ce_s2;
        logic                    ce_s3;
        logic [SENSE_INPUTS-1:0] sense_s1;
        logic [SENSE_INPUTS-1:0] sense_s2;
        control_type             ctrl;
        logic [DISP_BITS-1:0]    disp;
        logic                    lcd_drive;
        logic                    seg_off;
        logic                    com_as_seg;
        logic                    osc_ext;
        logic                    osc_run;
        scan_lines_type          scan;
        ports_type               ports;
        logic                    scan_start;
        logic                    key_clear;
        logic                    do_release;
    } sys_state_type;

    sys_state_type state_r;
    sys_state_type state_nxt;

    logic [ADDR_BITS-1:0]  frame_addr;
    logic [FRAME_BITS-1:0] frame_data;
    logic [COUNT_BITS-1:0] frame_count;

    serial_link_rx link_rx (
        .serial_clock_in (serial_clock_in),
        .rst_in          (rst_in),
        .chip_enable_in  (chip_enable_in),
        .serial_data_in  (serial_data_in),
        .frame_addr_out  (frame_addr),
        .frame_data_out  (frame_data),
        .frame_count_out (frame_count)
    );

    logic [SHARED_PORTS-1:0] port_bits;
    logic                    ce_fall;

    // Port level source bit depends on duty
    generate
        for (genvar i = 0; i < SHARED_PORTS; i++) begin : g_port_bit
            assign port_bits[i] = state_r.ctrl.duty_select_bit ?
                                  state_r.disp[i*PORT_STEP_THREE] :
                                  state_r.disp[i*PORT_STEP_FOUR];
        end
    endgenerate

    assign ce_fall = state_r.ce_s3 && !state_r.ce_s2;

    always_comb begin
        state_nxt = state_r;
        state_nxt.ce_s1    = chip_enable_in;
        state_nxt.ce_s2    = state_r.ce_s1;
        state_nxt.ce_s3    = state_r.ce_s2;
        state_nxt.sense_s1 = scan_sense_inputs_in;
        state_nxt.sense_s2 = state_r.sense_s1;

        // Link registers sit still once the serial clock stops after the frame, so sampling here is safe
        if (ce_fall) begin
            if (frame_addr == CTRL_ADDR && frame_count == CTRL_COUNT) begin
                state_nxt.ctrl = control_type'(frame_data[CTRL_BITS-1:0]);
            end else if (frame_addr == DISP_ADDR && frame_count == DISP_COUNT) begin
                state_nxt.disp = frame_data[DISP_BITS-1:0];
            end
        end

        // Sleep holds commons and segments low; blank keeps the waveforms running
        state_nxt.lcd_drive  = !state_r.ctrl.sleep_select;
        state_nxt.seg_off    = state_r.ctrl.segment_blank_bit;
        state_nxt.com_as_seg = state_r.ctrl.duty_select_bit;
        state_nxt.osc_ext    = state_r.ctrl.osc_source_bit;
        // Clock must keep running for a key scan even while asleep
        state_nxt.osc_run    = !state_r.ctrl.sleep_select || scan_busy_in;

        for (int i = 0; i < SCAN_LINES; i++) begin
            // Standby value 7 reads as all lines low
            state_nxt.scan.level[i] =
                (3'(i) >= state_r.ctrl.scan_standby_level_field);
            state_nxt.scan.drive_enable[i] =
                state_nxt.scan.level[i] && !state_r.ctrl.scan_disable_bit;
        end
        for (int i = 0; i < SHARED_SCAN; i++) begin
            state_nxt.scan.segment_select[i] =
                (2'(i) < state_r.ctrl.scan_pin_share_field);
            if (state_nxt.scan.segment_select[i]) begin
                state_nxt.scan.drive_enable[i] = 1'b0;
            end
        end

        // Port values 5 to 7 behave as 4
        for (int i = 0; i < SHARED_PORTS; i++) begin
            state_nxt.ports.port_mode[i] =
                (3'(i) < state_r.ctrl.port_select_field);
            state_nxt.ports.port_level[i] =
                state_nxt.ports.port_mode[i] && port_bits[i];
        end

        // Sense inputs only rise when a pressed key sits on a high line
        state_nxt.scan_start = !state_r.ctrl.scan_disable_bit && !scan_busy_in &&
                               !state_r.scan_start &&
                               (|state_r.sense_s2);
        state_nxt.key_clear  = state_r.ctrl.scan_disable_bit;
        state_nxt.do_release = state_r.ctrl.scan_disable_bit;

        if (rst_in) begin
            state_nxt.ctrl       = CTRL_RESET;
            state_nxt.disp       = '0;
            state_nxt.ce_s1      = 1'b0;
            state_nxt.ce_s2      = 1'b0;
            state_nxt.ce_s3      = 1'b0;
            state_nxt.sense_s1   = '0;
            state_nxt.sense_s2   = '0;
            state_nxt.lcd_drive  = 1'b0;
            state_nxt.seg_off    = 1'b1;
            state_nxt.com_as_seg = 1'b0;
            state_nxt.osc_ext    = 1'b0;
            state_nxt.osc_run    = 1'b1;
            state_nxt.scan       = '0;
            state_nxt.ports      = '0;
            state_nxt.scan_start = 1'b0;
            state_nxt.key_clear  = 1'b1;
            state_nxt.do_release = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        state_r <= state_nxt;
    end

    assign control_out                  = state_r.ctrl;
    assign lcd_drive_enable_out         = state_r.lcd_drive;
    assign segment_off_wave_out         = state_r.seg_off;
    assign shared_common_segment_out    = state_r.com_as_seg;
    assign osc_source_external_out      = state_r.osc_ext;
    assign osc_run_out                  = state_r.osc_run;
    assign scan_drive_lines_out         = state_r.scan;
    assign shared_segment_port_pins_out = state_r.ports;
    assign scan_start_out               = state_r.scan_start;
    assign key_data_clear_out           = state_r.key_clear;
    assign data_out_release_out         = state_r.do_release;

endmodule

// [verilog/lcd_keyscan_pkg.sv]
// Constants and carrier types for the LCD key-scan control decoder
// Contract
// - Control data can turn any of the four lowest segment pins into output ports.
// - In three-common operation the fourth common pin works as a segment output.
// - Duty bit 0 selects four commons; 1 selects three, shared pin as segment.
// - Oscillator pin serves as RC oscillator or external clock input per control data.
// - Oscillator-source bit 0 selects RC oscillator, 1 selects external clock.
// - Sleep bit 0 is normal mode with clock running and LCD waveforms driven.
// - Sleep stops the clock except during key scans and holds LCD outputs low.
// - Key scan state and port levels stay configurable while asleep.
// - Standby field n drives the first n scan lines low, the rest high.
// - No scan drive pulses on scan lines held low by the standby field.
// - With scans enabled, a key press on a high line starts a scan.
// - Scan disable stops scans, zeroes key data, cancels reads, releases data out.
// - Pin-share field turns the first zero to three scan pins into segments.
// - Port-select field n turns the first n shared segment pins into ports.
// - Port levels come from display bits 1,4,7,10 or 1,5,9,13 by duty.
// - A port drives high for display bit 1 and low for bit 0.
// - Blank bit 0 shows the display, 1 blanks all segments.
// - Blanking keeps driving segment-off waveforms, not static pins.
// - Controller uses chip enable high, serial clock and data; data out is open drain.
package lcd_keyscan_pkg;

    localparam int ADDR_BITS     = 8;
    localparam int COUNT_BITS    = 5;
    localparam int SCAN_LINES    = 6;
    localparam int SENSE_INPUTS  = 5;
    localparam int SHARED_SCAN   = 3;
    localparam int SHARED_PORTS  = 4;
    localparam int DISP_BITS     = 16;
    localparam int CTRL_BITS     = 17;
    localparam int FRAME_BITS    = 18;

    // Transfer addresses; values are arbitrary
    localparam logic [ADDR_BITS-1:0] CTRL_ADDR = 8'h81;
    localparam logic [ADDR_BITS-1:0] DISP_ADDR = 8'h82;

    localparam logic [COUNT_BITS-1:0] CTRL_COUNT = 5'h11;
    localparam logic [COUNT_BITS-1:0] DISP_COUNT = 5'h10;
    localparam logic [COUNT_BITS-1:0] COUNT_MAX  = 5'h1f;

    // Display bit index of each port: D1 is index 0
    localparam int PORT_STEP_THREE = 3;
    localparam int PORT_STEP_FOUR  = 4;

    // Field order is the order on the wire, first bit received at the top
    typedef struct packed {
        logic       sleep_select;
        logic [2:0] scan_standby_level_field;
        logic       scan_disable_bit;
        logic [1:0] scan_pin_share_field;
        logic [2:0] port_select_field;
        logic       segment_blank_bit;
        logic       bias_select_bit;
        logic       duty_select_bit;
        logic [2:0] frame_rate_field;
        logic       osc_source_bit;
    } control_type;

    // Display stays blank and scanning off until software programs it
    // Only scan disable and segment blank are set
    localparam control_type CTRL_RESET = 17'h0_1040;

    typedef struct packed {
        logic [ADDR_BITS-1:0]  addr;
        logic [ADDR_BITS-1:0]  frame_addr;
        logic [FRAME_BITS-1:0] data;
        logic [COUNT_BITS-1:0] count;
        logic                  in_data;
        logic [1:0]            rst_sync;
    } link_state_type;

    typedef struct packed {
        logic [SCAN_LINES-1:0]   level;
        logic [SCAN_LINES-1:0]   drive_enable;
        logic [SHARED_SCAN-1:0]  segment_select;
    } scan_lines_type;

    typedef struct packed {
        logic [SHARED_PORTS-1:0] port_mode;
        logic [SHARED_PORTS-1:0] port_level;
    } ports_type;

endpackage

// [verilog/serial_link_rx.sv]
// Serial link receiver running on the controller's clock
module serial_link_rx
    import lcd_keyscan_pkg::*;
(
    input  wire logic                  serial_clock_in,
    input  wire logic                  rst_in,
    input  wire logic                  chip_enable_in,
    input  wire logic                  serial_data_in,
    output logic [ADDR_BITS-1:0]       frame_addr_out,
    output logic [FRAME_BITS-1:0]      frame_data_out,
    output logic [COUNT_BITS-1:0]      frame_count_out
);

    link_state_type state_r;
    link_state_type state_nxt;

    always_comb begin
        state_nxt = state_r;
        state_nxt.rst_sync = {state_r.rst_sync[0], rst_in};
        if (state_r.rst_sync[1]) begin
            state_nxt.count   = '0;
            state_nxt.in_data = 1'b0;
        end else if (!chip_enable_in) begin
            // Address phase clocks while chip enable is low, which restarts the count
            state_nxt.addr    = {state_r.addr[ADDR_BITS-2:0], serial_data_in};
            state_nxt.count   = '0;
            state_nxt.in_data = 1'b0;
        end else begin
            // Address is frozen on the first data bit so it stays stable for the reader
            if (!state_r.in_data) begin
                state_nxt.frame_addr = state_r.addr;
                state_nxt.in_data    = 1'b1;
            end
            state_nxt.data = {state_r.data[FRAME_BITS-2:0], serial_data_in};
            if (state_r.count != COUNT_MAX) begin
                state_nxt.count = state_r.count + 5'h01;
            end
        end
    end

    always_ff @(posedge serial_clock_in) begin
        state_r <= state_nxt;
    end

    assign frame_addr_out  = state_r.frame_addr;
    assign frame_data_out  = state_r.data;
    assign frame_count_out = state_r.count;

endmodule
